/* File: spcfg_top.sv */
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - code 00 default: pin shows ready/busy level
// - code 01: pulse on erase completion
// - code 10: pulse on program completion
// - code 11: pulse on erase or program
// - B8h then code byte selects mode
// - pulse drives pin low about 250 ns
// - erase pulse on single or queued end
// - status ready bit: 1 ready, 0 busy
// - ready indication sits in status bit 7
// - invalid code sets both error bits
module spcfg_top
    import spcfg_pkg::*;
#(
    parameter int PULSE_CYC = SPCFG_PULSE_CYC
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [SPCFG_AW-1:0] reg_addr,
    input wire logic [SPCFG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [SPCFG_DW-1:0] reg_rdata,
    // write sequencer
    input wire logic seq_busy,
    input wire logic erase_done,
    input wire logic erase_queue_pending,
    input wire logic program_done,
    // completion pin, open drain
    input wire logic completion_signal_pin_i,
    output logic completion_signal_pin_o,
    output logic completion_signal_pin_oe,
    // interrupt
    output logic irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    spcfg_link_if lnk ();

    spcfg_mode_t mode_r;
    logic prog_err_r;
    logic erase_err_r;
    logic seq_busy_d_r;
    logic pin_oe_r;
    logic [SPCFG_DW-1:0] rdata_r;
    logic [SPCFG_IRQ_W-1:0] irq_stat_r;
    logic [SPCFG_IRQ_W-1:0] irq_stat_nxt;
    logic [SPCFG_IRQ_W-1:0] irq_mask_r;
    logic [SPCFG_IRQ_W-1:0] irq_evt;
    logic irq_r;
    logic [7:0] pulse_cnt_r;
    logic [7:0] rej_cnt_r;
    logic erase_evt;
    logic prog_evt;
    logic ready_evt;
    logic fire;
    logic clr_err;
    logic irq_stat_rd;
    logic [SPCFG_DW-1:0] status_byte;
    logic [SPCFG_DW-1:0] rd_mux;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic reg_hit(input logic strobe, input logic [SPCFG_AW-1:0] a,
                                     input logic [SPCFG_AW-1:0] ofs);
        reg_hit = strobe && (a == ofs);
    endfunction

    function automatic logic [SPCFG_DW-1:0] zext_irq(input logic [SPCFG_IRQ_W-1:0] v);
        zext_irq = {{(SPCFG_DW - SPCFG_IRQ_W){1'b0}}, v};
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    // ****************************************************************
    // submodules
    // ****************************************************************
    assign lnk.cmd_valid = reg_hit(reg_wr, reg_addr, SPCFG_OFS_CMD);
    assign lnk.cmd_byte = reg_wdata;
    assign lnk.fire = fire;

    spcfg_cmd_dec u_dec (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .lnk(lnk.dec)
    );

    spcfg_pulse_gen #(
        .PULSE_CYC(PULSE_CYC)
    ) u_pulse (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .lnk(lnk.pul)
    );

    // ****************************************************************
    // completion events
    // ****************************************************************
    // an erase inside a queue stays quiet; only the last one counts
    assign erase_evt = erase_done && !erase_queue_pending;
    assign prog_evt = program_done;
    assign ready_evt = seq_busy_d_r && !seq_busy;

    always_comb begin
        fire = 1'b0;
        unique case (mode_r)
            SPCFG_READY_BUSY_LEVEL_MODE: fire = 1'b0;
            SPCFG_ERASE_DONE_PULSE_MODE: fire = erase_evt;
            SPCFG_PROGRAM_DONE_PULSE_MODE: fire = prog_evt;
            SPCFG_ANY_DONE_PULSE_MODE: fire = erase_evt || prog_evt;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            seq_busy_d_r <= 1'b0;
        end else if (clk_en) begin
            seq_busy_d_r <= seq_busy;
        end
    end

    // ****************************************************************
    // pin mode
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mode_r <= SPCFG_MODE_RST;
        end else if (clk_en && lnk.cfg_load) begin
            mode_r <= spcfg_mode_t'(lnk.cfg_code);
        end
    end

    // ****************************************************************
    // completion pin drive
    // ****************************************************************
    // open drain: the pin is only ever pulled low, released otherwise
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_oe_r <= 1'b0;
        end else if (clk_en) begin
            if (mode_r == SPCFG_READY_BUSY_LEVEL_MODE) begin
                pin_oe_r <= seq_busy;
            end else begin
                pin_oe_r <= lnk.pulse_active || fire;
            end
        end
    end

    assign completion_signal_pin_o = 1'b0;
    assign completion_signal_pin_oe = pin_oe_r;

    // ****************************************************************
    // status byte error bits
    // ****************************************************************
    assign clr_err = reg_hit(reg_wr, reg_addr, SPCFG_OFS_CLR_ERR);

    // a fresh error beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prog_err_r <= 1'b0;
            erase_err_r <= 1'b0;
        end else if (clk_en) begin
            if (lnk.cfg_err) begin
                prog_err_r <= 1'b1;
                erase_err_r <= 1'b1;
            end else if (clr_err) begin
                prog_err_r <= 1'b0;
                erase_err_r <= 1'b0;
            end
        end
    end

    always_comb begin
        status_byte = 8'h00;
        status_byte[SPCFG_SR_READY_BIT] = !seq_busy;
        status_byte[SPCFG_SR_ERASE_ERR_BIT] = erase_err_r;
        status_byte[SPCFG_SR_PROG_ERR_BIT] = prog_err_r;
    end

    // ****************************************************************
    // diagnostic counters
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pulse_cnt_r <= 8'h00;
        end else if (clk_en && fire) begin
            pulse_cnt_r <= sat_inc(pulse_cnt_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rej_cnt_r <= 8'h00;
        end else if (clk_en && lnk.cfg_err) begin
            rej_cnt_r <= sat_inc(rej_cnt_r);
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    always_comb begin
        irq_evt = '0;
        irq_evt[SPCFG_IRQ_ERASE_BIT] = erase_evt;
        irq_evt[SPCFG_IRQ_PROG_BIT] = prog_evt;
        irq_evt[SPCFG_IRQ_CFG_ERR_BIT] = lnk.cfg_err;
        irq_evt[SPCFG_IRQ_READY_BIT] = ready_evt;
    end

    assign irq_stat_rd = reg_hit(reg_rd, reg_addr, SPCFG_OFS_IRQ_STAT);

    // read clears, but an event in the same cycle stays set
    always_comb begin
        irq_stat_nxt = irq_stat_rd ? irq_evt : (irq_stat_r | irq_evt);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_stat_r <= '0;
        end else if (clk_en) begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_mask_r <= SPCFG_IRQ_MASK_RST;
        end else if (clk_en && reg_hit(reg_wr, reg_addr, SPCFG_OFS_IRQ_MASK)) begin
            irq_mask_r <= reg_wdata[SPCFG_IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else if (clk_en) begin
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    assign irq = irq_r;

    // ****************************************************************
    // register read
    // ****************************************************************
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            SPCFG_OFS_STATUS: rd_mux = status_byte;
            SPCFG_OFS_MODE: rd_mux = {6'h00, mode_r};
            SPCFG_OFS_IRQ_STAT: rd_mux = zext_irq(irq_stat_r);
            SPCFG_OFS_IRQ_MASK: rd_mux = zext_irq(irq_mask_r);
            SPCFG_OFS_PULSE_CNT: rd_mux = pulse_cnt_r;
            SPCFG_OFS_REJ_CNT: rd_mux = rej_cnt_r;
            default: rd_mux = 8'h00;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (clk_en) begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

endmodule // spcfg_top

/* File: spcfg_pkg.sv */
package spcfg_pkg;

    // ****************************************************************
    // register bus
    // ****************************************************************
    localparam int SPCFG_AW = 4;
    localparam int SPCFG_DW = 8;
    localparam logic [3:0] SPCFG_OFS_CMD = 4'h0;
    localparam logic [3:0] SPCFG_OFS_STATUS = 4'h1;
    localparam logic [3:0] SPCFG_OFS_MODE = 4'h2;
    localparam logic [3:0] SPCFG_OFS_IRQ_STAT = 4'h3;
    localparam logic [3:0] SPCFG_OFS_IRQ_MASK = 4'h4;
    localparam logic [3:0] SPCFG_OFS_CLR_ERR = 4'h5;
    localparam logic [3:0] SPCFG_OFS_PULSE_CNT = 4'h6;
    localparam logic [3:0] SPCFG_OFS_REJ_CNT = 4'h7;

    // ****************************************************************
    // command and field layout
    // ****************************************************************
    localparam logic [7:0] SPCFG_CMD_PIN_CFG = 8'hB8;
    localparam int SPCFG_CODE_LSB = 0;
    localparam int SPCFG_CODE_W = 2;
    localparam int SPCFG_RSVD_LSB = 2;
    localparam int SPCFG_RSVD_W = 6;
    localparam int SPCFG_SR_READY_BIT = 7;
    localparam int SPCFG_SR_ERASE_ERR_BIT = 5;
    localparam int SPCFG_SR_PROG_ERR_BIT = 4;

    // ****************************************************************
    // pin modes
    // ****************************************************************
    typedef enum logic [1:0] {
        SPCFG_READY_BUSY_LEVEL_MODE = 2'h0,
        SPCFG_ERASE_DONE_PULSE_MODE = 2'h1,
        SPCFG_PROGRAM_DONE_PULSE_MODE = 2'h2,
        SPCFG_ANY_DONE_PULSE_MODE = 2'h3
    } spcfg_mode_t;
    localparam spcfg_mode_t SPCFG_MODE_RST = SPCFG_READY_BUSY_LEVEL_MODE;

    // ****************************************************************
    // interrupt status layout
    // ****************************************************************
    localparam int SPCFG_IRQ_W = 4;
    localparam int SPCFG_IRQ_ERASE_BIT = 0;
    localparam int SPCFG_IRQ_PROG_BIT = 1;
    localparam int SPCFG_IRQ_CFG_ERR_BIT = 2;
    localparam int SPCFG_IRQ_READY_BIT = 3;
    localparam logic [3:0] SPCFG_IRQ_MASK_RST = 4'h0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SPCFG_CLK_PERIOD_PS = 5000;
    localparam int SPCFG_PULSE_NS = 250;
    localparam int SPCFG_PULSE_CYC =
        (SPCFG_PULSE_NS * 1000 + SPCFG_CLK_PERIOD_PS - 1) / SPCFG_CLK_PERIOD_PS;

endpackage

/* File: spcfg_link_if.sv */
`timescale 1ns/1ps
interface spcfg_link_if;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cfg_load;
    logic [1:0] cfg_code;
    logic cfg_err;
    logic fire;
    logic pulse_active;

    modport dec (input cmd_valid, input cmd_byte, output cfg_load, output cfg_code,
        output cfg_err);
    modport pul (input fire, output pulse_active);
    modport top (output cmd_valid, output cmd_byte, input cfg_load, input cfg_code,
        input cfg_err, output fire, input pulse_active);
endinterface

/* File: spcfg_cmd_dec.sv */
`timescale 1ns/1ps
module spcfg_cmd_dec
    import spcfg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // link to top
    spcfg_link_if.dec lnk
);

    typedef enum logic {SPCFG_DEC_IDLE, SPCFG_DEC_ARMED} spcfg_dec_state_t;

    spcfg_dec_state_t state_r;
    logic load_r;
    logic err_r;
    logic [1:0] code_r;
    logic rsvd_zero;

    assign rsvd_zero = (lnk.cmd_byte[SPCFG_RSVD_LSB +: SPCFG_RSVD_W] == 6'h00);

    // ****************************************************************
    // two-write setup and confirm
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r <= SPCFG_DEC_IDLE;
            load_r <= 1'b0;
            err_r <= 1'b0;
            code_r <= 2'h0;
        end else if (clk_en) begin
            load_r <= 1'b0;
            err_r <= 1'b0;
            if (lnk.cmd_valid) begin
                unique case (state_r)
                    SPCFG_DEC_IDLE: begin
                        if (lnk.cmd_byte == SPCFG_CMD_PIN_CFG) begin
                            state_r <= SPCFG_DEC_ARMED;
                        end
                    end
                    SPCFG_DEC_ARMED: begin
                        state_r <= SPCFG_DEC_IDLE;
                        if (rsvd_zero) begin
                            load_r <= 1'b1;
                            code_r <= lnk.cmd_byte[SPCFG_CODE_LSB +: SPCFG_CODE_W];
                        end else begin
                            err_r <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign lnk.cfg_load = load_r;
    assign lnk.cfg_err = err_r;
    assign lnk.cfg_code = code_r;

endmodule // spcfg_cmd_dec

/* File: spcfg_pulse_gen.sv */
`timescale 1ns/1ps
module spcfg_pulse_gen
    import spcfg_pkg::*;
#(
    parameter int PULSE_CYC = SPCFG_PULSE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // link to top
    spcfg_link_if.pul lnk
);

    localparam int CW = $clog2(PULSE_CYC + 1);
    localparam logic [CW-1:0] LOAD_VAL = CW'(PULSE_CYC);

    logic [CW-1:0] cnt_r;

    // ****************************************************************
    // low pulse timer
    // ****************************************************************
    // a new event during a pulse restarts it; back-to-back events merge
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            if (lnk.fire) begin
                cnt_r <= LOAD_VAL;
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign lnk.pulse_active = (cnt_r != '0);

endmodule // spcfg_pulse_gen

/* File: spcfg_top_sva.sv */
`timescale 1ns/1ps
module spcfg_top_sva
    import spcfg_pkg::*;
#(
    parameter int PULSE_CYC = SPCFG_PULSE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [SPCFG_AW-1:0] reg_addr,
    input wire logic [SPCFG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [SPCFG_DW-1:0] reg_rdata,
    // write sequencer
    input wire logic seq_busy,
    input wire logic erase_done,
    input wire logic erase_queue_pending,
    input wire logic program_done,
    // pin and interrupt
    input wire logic completion_signal_pin_i,
    input wire logic completion_signal_pin_o,
    input wire logic completion_signal_pin_oe,
    input wire logic irq
);
    // ****
    // shadow of the selected mode
    // ****
    logic armed_r;
    logic [1:0] mode_r, m1_r, m2_r, m3_r;
    logic [7:0] hi_cnt_r;
    logic stab, sel_e, sel_p;
    // mode must sit still a few cycles, the design applies it two edges late
    assign stab = (mode_r == m1_r) && (m1_r == m2_r) && (m2_r == m3_r);
    assign sel_e = stab && mode_r[0];
    assign sel_p = stab && mode_r[1];
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            armed_r <= 1'b0;
            mode_r <= SPCFG_MODE_RST;
        end else if (reg_wr && reg_addr == SPCFG_OFS_CMD) begin
            armed_r <= !armed_r && reg_wdata == SPCFG_CMD_PIN_CFG;
            if (armed_r && reg_wdata[7:2] == 6'h00) begin
                mode_r <= reg_wdata[1:0];
            end
        end
    end
    always_ff @(posedge mclk) begin
        m1_r <= rst_b ? mode_r : 2'h0;
        m2_r <= rst_b ? m1_r : 2'h0;
        m3_r <= rst_b ? m2_r : 2'h0;
    end
    always_ff @(posedge mclk) begin
        hi_cnt_r <= (rst_b && completion_signal_pin_oe) ? hi_cnt_r + 8'h01 : 8'h00;
    end
    // ****
    // checks
    // ****
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence erase_evt;
        erase_done && !erase_queue_pending;
    endsequence
    sequence prog_evt;
        program_done;
    endsequence
    level_follow_a: assert property (stab && mode_r == 2'h0 && $past(rst_b)
        |-> completion_signal_pin_oe == $past(seq_busy)) else $error("level pin wrong");
    erase_fire_a: assert property (sel_e ##0 erase_evt
        |=> completion_signal_pin_oe) else $error("no erase pulse");
    prog_fire_a: assert property (sel_p ##0 prog_evt
        |=> completion_signal_pin_oe) else $error("no program pulse");
    no_fire_a: assert property (stab && mode_r != 2'h0 && !completion_signal_pin_oe
        && !(sel_e && erase_done && !erase_queue_pending) && !(sel_p && program_done)
        |=> !completion_signal_pin_oe) else $error("stray pulse");
    pulse_width_a: assert property ($fell(completion_signal_pin_oe) && stab && mode_r != 2'h0
        |-> hi_cnt_r == PULSE_CYC + 1) else $error("pulse width wrong");
    drive_low_a: assert property (completion_signal_pin_o == 1'b0) else $error("pin not low");
    ready_bit_a: assert property (reg_rd && reg_addr == SPCFG_OFS_STATUS
        |=> reg_rdata[7] == !$past(seq_busy)) else $error("ready bit wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    mask_off_a: assert property (reg_wr && reg_addr == SPCFG_OFS_IRQ_MASK && reg_wdata[3:0] == 4'h0
        |-> ##2 !irq) else $error("irq with mask off");
endmodule // spcfg_top_sva

bind spcfg_top spcfg_top_sva #(.PULSE_CYC(PULSE_CYC)) spcfg_top_sva_i (.mclk(mclk),
    .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_busy(seq_busy),
    .erase_done(erase_done), .erase_queue_pending(erase_queue_pending),
    .program_done(program_done), .completion_signal_pin_i(completion_signal_pin_i),
    .completion_signal_pin_o(completion_signal_pin_o),
    .completion_signal_pin_oe(completion_signal_pin_oe), .irq(irq));

/* File: spcfg_host_model.sv */
`timescale 1ns/1ps
module spcfg_host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // open-drain pin
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_level,
    // observations
    output logic [7:0] pulse_cnt,
    output logic [7:0] last_width
);
    logic prev;
    logic [7:0] low_cnt;
    // board pull-up holds the line high when released
    assign pin_level = pin_oe ? pin_o : 1'b1;
    always @(posedge mclk) begin
        if (!rst_b) begin
            prev <= 1'b1;
            low_cnt <= 8'h00;
            pulse_cnt <= 8'h00;
            last_width <= 8'h00;
        end else begin
            prev <= pin_level;
            if (!pin_level) begin
                low_cnt <= low_cnt + 8'h01;
            end else if (!prev) begin
                last_width <= low_cnt;
                low_cnt <= 8'h00;
            end
            if (prev && !pin_level) begin
                pulse_cnt <= pulse_cnt + 8'h01;
            end
        end
    end
endmodule // spcfg_host_model

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
    import spcfg_pkg::*;
    localparam int PCYC = 4;
    logic mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, pulse_cnt, last_width, n;
    logic seq_busy = 1'b0, erase_done = 1'b0, erase_queue_pending = 1'b0, program_done = 1'b0;
    logic pin_o, pin_oe, pin_level, irq;
    int error_cnt = 0, total_checks = 0;
    always #2.5 mclk = ~mclk;
    spcfg_top #(.PULSE_CYC(PCYC)) spcfg_top_i (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .seq_busy(seq_busy), .erase_done(erase_done),
        .erase_queue_pending(erase_queue_pending), .program_done(program_done),
        .completion_signal_pin_i(pin_level), .completion_signal_pin_o(pin_o),
        .completion_signal_pin_oe(pin_oe), .irq(irq));
    spcfg_host_model spcfg_host_model_i (.mclk(mclk), .rst_b(rst_b), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_level(pin_level), .pulse_cnt(pulse_cnt), .last_width(last_width));
    // ****
    // bus and event tasks, each starts on a rising edge
    // ****
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
    endtask
    task automatic idle();
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        `CHK(reg_rdata, e)
    endtask
    task automatic cfg(input logic [7:0] code);
        wr(SPCFG_OFS_CMD, SPCFG_CMD_PIN_CFG);
        wr(SPCFG_OFS_CMD, code);
        idle();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic ev(input logic e, input logic p, input logic q);
        @(posedge mclk);
        erase_done <= e;
        program_done <= p;
        erase_queue_pending <= q;
        @(posedge mclk);
        erase_done <= 1'b0;
        program_done <= 1'b0;
        erase_queue_pending <= 1'b0;
        cyc(12);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
    // ****
    // main sequence
    // ****
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        chk_rd(SPCFG_OFS_MODE, 8'h00);
        chk_rd(SPCFG_OFS_STATUS, 8'h80);
        chk_rd(4'hF, 8'h00);
        wr(SPCFG_OFS_IRQ_MASK, 8'h0F);
        idle();
        seq_busy <= 1'b1;
        cyc(3);
        `CHK(pin_level, 1'b0)
        chk_rd(SPCFG_OFS_STATUS, 8'h00);
        @(posedge mclk);
        seq_busy <= 1'b0;
        cyc(4);
        `CHK(pin_level, 1'b1)
        `CHK(irq, 1'b1)
        chk_rd(SPCFG_OFS_IRQ_STAT, 8'h08);
        cyc(3);
        `CHK(irq, 1'b0)
        // masked event still latches but keeps the line quiet
        wr(SPCFG_OFS_IRQ_MASK, 8'h00);
        seq_busy <= 1'b1;
        idle();
        seq_busy <= 1'b0;
        cyc(4);
        `CHK(irq, 1'b0)
        chk_rd(SPCFG_OFS_IRQ_MASK, 8'h00);
        chk_rd(SPCFG_OFS_IRQ_STAT, 8'h08);
        for (int c = 0; c < 4; c++) begin
            n = pulse_cnt;
            cfg(8'(c));
            chk_rd(SPCFG_OFS_MODE, 8'(c));
            ev(1'b1, 1'b0, 1'b0);
            `CHK(pulse_cnt, 8'(n + c[0]))
            ev(1'b0, 1'b1, 1'b0);
            `CHK(pulse_cnt, 8'(n + c[0] + c[1]))
            if (c != 0) `CHK(last_width, 8'(PCYC + 1))
        end
        cfg(8'h01);
        n = pulse_cnt;
        ev(1'b1, 1'b0, 1'b1);
        `CHK(pulse_cnt, n)
        ev(1'b1, 1'b0, 1'b0);
        `CHK(pulse_cnt, 8'(n + 8'h01))
        for (int i = 0; i < 2; i++) begin
            cfg(i == 0 ? 8'h05 : SPCFG_CMD_PIN_CFG);
            chk_rd(SPCFG_OFS_STATUS, 8'hB0);
            chk_rd(SPCFG_OFS_MODE, 8'h01);
            wr(SPCFG_OFS_CLR_ERR, 8'h00);
            idle();
            chk_rd(SPCFG_OFS_STATUS, 8'h80);
        end
        chk_rd(SPCFG_OFS_PULSE_CNT, 8'h05);
        chk_rd(SPCFG_OFS_REJ_CNT, 8'h02);
        chk_rd(SPCFG_OFS_IRQ_STAT, 8'h07);
        // a frozen clock enable must swallow the write
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(SPCFG_OFS_IRQ_MASK, 8'h0F);
        idle();
        clk_en <= 1'b1;
        chk_rd(SPCFG_OFS_IRQ_MASK, 8'h00);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chk_rd(SPCFG_OFS_MODE, 8'h00);
        summarize();
    end
endmodule // testbench
